// File: rtl/sfwp_regs.svh
// Constants of the flash write-protection block: opcodes, bits, timing
`ifndef SFWP_REGS_SVH
`define SFWP_REGS_SVH

// Instruction opcodes
`define SFWP_OP_WREN 8'h06
`define SFWP_OP_WRDI 8'h04
`define SFWP_OP_RDSR_LO 8'h05
`define SFWP_OP_RDSR_HI 8'h35
`define SFWP_OP_WRSR 8'h01
`define SFWP_OP_PP 8'h02
`define SFWP_OP_QPP 8'h32
`define SFWP_OP_SE 8'h20
`define SFWP_OP_BE32 8'h52
`define SFWP_OP_BE64 8'hD8
`define SFWP_OP_CE_A 8'h60
`define SFWP_OP_CE_B 8'hC7
`define SFWP_OP_SREG_ERASE 8'h44
`define SFWP_OP_SREG_PROG 8'h42
`define SFWP_OP_PD 8'hB9
`define SFWP_OP_RPD 8'hAB
`define SFWP_OP_PAUSE_A 8'h75
`define SFWP_OP_PAUSE_B 8'hB0
`define SFWP_OP_RES_A 8'h7A
`define SFWP_OP_RES_B 8'h30

// Bit counts of complete frames
`define SFWP_BITS_OP 6'h08
`define SFWP_BITS_SR1 6'h10
`define SFWP_BITS_SR2 6'h18
`define SFWP_BITS_ADDR 6'h20
`define SFWP_BITS_DATA 6'h28
`define SFWP_BITS_MAX 6'h3F

// Positions in the 16-bit status word
`define SFWP_S_BUSY 0
`define SFWP_S_WLATCH 1
`define SFWP_S_BP_LO 2
`define SFWP_S_BP_HI 4
`define SFWP_S_TOPBOT 5
`define SFWP_S_GRAN 6
`define SFWP_S_GUARD 7
`define SFWP_S_LOCKDN 8
`define SFWP_S_QUAD 9
`define SFWP_S_SLOCK_LO 11
`define SFWP_S_SLOCK_HI 13
`define SFWP_S_INV 14
`define SFWP_S_PAUSE 15

// Reset values of the nonvolatile fields
`define SFWP_BP_RST 3'h0
`define SFWP_SLOCK_RST 3'h0

// Array geometry in bytes
`define SFWP_ARRAY 22'h20_0000
`define SFWP_BLOCK64 22'h01_0000
`define SFWP_BLOCK32 22'h00_8000
`define SFWP_SECTOR 22'h00_1000
`define SFWP_PAGE 22'h00_0100

// Timing: clock rate in MHz, times in microseconds, cycles derived
`define SFWP_CLK_MHZ 50
`define SFWP_T_STATUS_US 3000
`define SFWP_T_PROG_US 1500
`define SFWP_T_SERASE_US 3000
`define SFWP_T_BERASE_US 3000
`define SFWP_T_CHIP_US 6000
`define SFWP_T_PUW_US 1000
`define SFWP_T_STATUS_CYC (`SFWP_T_STATUS_US * `SFWP_CLK_MHZ)
`define SFWP_T_PROG_CYC (`SFWP_T_PROG_US * `SFWP_CLK_MHZ)
`define SFWP_T_SERASE_CYC (`SFWP_T_SERASE_US * `SFWP_CLK_MHZ)
`define SFWP_T_BERASE_CYC (`SFWP_T_BERASE_US * `SFWP_CLK_MHZ)
`define SFWP_T_CHIP_CYC (`SFWP_T_CHIP_US * `SFWP_CLK_MHZ)
`define SFWP_T_PUW_CYC (`SFWP_T_PUW_US * `SFWP_CLK_MHZ)

`endif

// File: rtl/sfwp_pkg.sv
// Types of the flash write-protection block
package sfwp_pkg;
	typedef enum logic [1:0] {SFWP_IDLE, SFWP_RUN, SFWP_PAUSED} sfwp_act_t;
endpackage : sfwp_pkg

// File: rtl/sfwp_spi_front.sv
// Pin synchronisers and edge finders for the serial bus
`timescale 1ns/1ps
module sfwp_spi_front
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sclkPin,
	input wire logic csNPin,
	input wire logic mosiPin,
	input wire logic wpNPin,
	input wire logic supplyPin,
	output logic sclkRise,
	output logic sclkFall,
	output logic csRise,
	output logic csActive,
	output logic mosiBit,
	output logic wpN,
	output logic supplyOk
);
	import sfwp_pkg::*;

	// Bits: 0 clock, 1 select, 2 data, 3 guard pin, 4 supply
	logic [4:0] meta;
	logic [4:0] sync;
	logic [4:0] prev;
	logic [4:0] next_meta;
	logic [4:0] next_sync;
	logic [4:0] next_prev;

	// Two-stage capture, third stage only for edges
	always_comb
	begin
		next_meta = {supplyPin, wpNPin, mosiPin, csNPin, sclkPin};
		next_sync = meta;
		next_prev = sync;
	end

	// Select idles high, everything else low
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= 5'h02;
			sync <= 5'h02;
			prev <= 5'h02;
		end
		else
		begin
			meta <= next_meta;
			sync <= next_sync;
			prev <= next_prev;
		end
	end

	// Clock edges count only inside a selected frame
	assign csActive = ~sync[1];
	assign csRise = sync[1] & ~prev[1];
	assign sclkRise = sync[0] & ~prev[0] & ~sync[1];
	assign sclkFall = ~sync[0] & prev[0] & ~sync[1];
	assign mosiBit = sync[2];
	assign wpN = sync[3];
	assign supplyOk = sync[4];
endmodule : sfwp_spi_front

// File: rtl/sfwp_protect.sv
// Write protection and status control of a serial NOR flash
// How it works
// - Supply below inhibit level holds volatile state reset, no instruction taken.
// - After supply rises, writes and write enable wait the power-up delay.
// - Power-up clears the write latch.
// - Program, erase and status write need the write latch set first.
// - Write enable sets the latch, read back at status bit 1.
// - Write disable and every started write operation clear the latch.
// - Busy bit 0 is high while a write operation runs.
// - While busy only status read and suspend of a program or erase are taken.
// - In power-down only release power-down is taken.
// - Protect level bits 4..2 written by status write, default zero.
// - Top/bottom bit picks where the protected range starts.
// - Granularity bit picks 4KB sectors or 64KB blocks.
// - Guard bit clear: guard pin ignored, status write needs the write latch.
// - Guard bit set: guard pin low refuses status writes.
// - Guard pin counts only while quad lanes are off.
// - Suspend sets the paused flag; resume or power cycle clears it.
// - Invert bit swaps protected and unprotected regions.
// - Security lock bits only set, then their register stays read-only.
// - Quad enable bit turns guard and pause pins into lanes.
// - Program or erase touching a protected region is ignored.
// - Lock-down bit refuses status writes until the next power cycle.
// - Quad instructions are taken only with quad enable set.
`timescale 1ns/1ps
`include "sfwp_regs.svh"
module sfwp_protect
#(
	parameter int unsigned T_STATUS_CYC = `SFWP_T_STATUS_CYC,
	parameter int unsigned T_PROG_CYC = `SFWP_T_PROG_CYC,
	parameter int unsigned T_SERASE_CYC = `SFWP_T_SERASE_CYC,
	parameter int unsigned T_BERASE_CYC = `SFWP_T_BERASE_CYC,
	parameter int unsigned T_CHIP_CYC = `SFWP_T_CHIP_CYC,
	parameter int unsigned T_PUW_CYC = `SFWP_T_PUW_CYC
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sclkPin,
	input wire logic csNPin,
	input wire logic mosiPin,
	input wire logic wpNPin,
	input wire logic supplyPin,
	output logic miso,
	output logic misoOe,
	output logic busy,
	output logic writeLatch,
	output logic quadIoEnable
);
	import sfwp_pkg::*;

	logic sclkRise, sclkFall, csRise, csActive, mosiBit, wpSync, supplyOk;
	logic [5:0] bitCnt, next_bitCnt;
	logic [31:0] shiftSr, next_shiftSr;
	logic [7:0] opcode, next_opcode;
	logic [20:0] addr, next_addr;
	logic reading, next_reading, readHigh, next_readHigh;
	logic [2:0] outIdx, next_outIdx;
	logic next_miso, next_misoOe;
	sfwp_act_t act, next_act;
	logic next_busy, next_writeLatch, next_quadIoEnable;
	logic pausedOpFlag, next_pausedOpFlag, statusLockDown, next_statusLockDown;
	logic pwrDown, next_pwrDown, puDone, next_puDone;
	logic runIsStatus, next_runIsStatus;
	logic [31:0] puCnt, next_puCnt, timer, next_timer, dur;
	logic [2:0] protectLevel, next_protectLevel;
	logic [2:0] securityLock, next_securityLock;
	logic topBottomSelect, next_topBottomSelect;
	logic granularitySelect, next_granularitySelect;
	logic statusWriteGuard, next_statusWriteGuard;
	logic invertProtection, next_invertProtection;
	logic [15:0] statusWord, newWord;
	logic [21:0] span, tLo, tHi;
	logic freeOk, guardBlock, hit, lockHit, fmtOk;
	logic wrenGo, wrdiGo, srGo, arrGo, secGo, startOp;
	logic suspendGo, resumeGo, pdGo, rpdGo, endRun;

	sfwp_spi_front u_front
	(
		.mclk(mclk),
		.rstn(rstn),
		.sclkPin(sclkPin),
		.csNPin(csNPin),
		.mosiPin(mosiPin),
		.wpNPin(wpNPin),
		.supplyPin(supplyPin),
		.sclkRise(sclkRise),
		.sclkFall(sclkFall),
		.csRise(csRise),
		.csActive(csActive),
		.mosiBit(mosiBit),
		.wpN(wpSync),
		.supplyOk(supplyOk)
	);

	// True when opcode is one of two values
	function automatic logic op_is(input logic [7:0] op, input logic [7:0] a,
		input logic [7:0] b);
		op_is = (op == a) || (op == b);
	endfunction : op_is

	// True when the target range touches protected array
	function automatic logic prot_hit(input logic [2:0] lvl,
		input logic bottom, input logic fine, input logic inv,
		input logic [21:0] lo, input logic [21:0] hi);
		logic [21:0] size;
		logic [21:0] pLo;
		logic [21:0] pHi;
		logic [2:0] sh;
		sh = (fine && lvl[2]) ? 3'h3 : lvl - 3'h1;
		if (lvl == 3'h0)
			size = 22'h00_0000;
		else if (lvl[2:1] == 2'b11)
			size = `SFWP_ARRAY;
		else
			size = (fine ? `SFWP_SECTOR : `SFWP_BLOCK64) << sh;
		pLo = bottom ? 22'h00_0000 : `SFWP_ARRAY - size;
		pHi = bottom ? size : `SFWP_ARRAY;
		prot_hit = inv ? ((lo < pLo) || (hi > pHi)) : ((lo < pHi) && (pLo < hi));
	endfunction : prot_hit

	// Live status word, read-only bits included
	always_comb
	begin
		statusWord = 16'h0000;
		statusWord[`SFWP_S_BUSY] = busy;
		statusWord[`SFWP_S_WLATCH] = writeLatch;
		statusWord[`SFWP_S_BP_HI:`SFWP_S_BP_LO] = protectLevel;
		statusWord[`SFWP_S_TOPBOT] = topBottomSelect;
		statusWord[`SFWP_S_GRAN] = granularitySelect;
		statusWord[`SFWP_S_GUARD] = statusWriteGuard;
		statusWord[`SFWP_S_LOCKDN] = statusLockDown;
		statusWord[`SFWP_S_QUAD] = quadIoEnable;
		statusWord[`SFWP_S_SLOCK_HI:`SFWP_S_SLOCK_LO] = securityLock;
		statusWord[`SFWP_S_INV] = invertProtection;
		statusWord[`SFWP_S_PAUSE] = pausedOpFlag;
	end

	// Target span of an array write, and its duration
	always_comb
	begin
		span = `SFWP_PAGE;
		dur = T_PROG_CYC;
		fmtOk = 1'b0;
		case (opcode)
			`SFWP_OP_PP: fmtOk = bitCnt >= `SFWP_BITS_DATA;
			`SFWP_OP_QPP: fmtOk = quadIoEnable && (bitCnt >= `SFWP_BITS_ADDR);
			`SFWP_OP_SE:
			begin
				span = `SFWP_SECTOR;
				dur = T_SERASE_CYC;
				fmtOk = bitCnt == `SFWP_BITS_ADDR;
			end
			`SFWP_OP_BE32:
			begin
				span = `SFWP_BLOCK32;
				dur = T_BERASE_CYC;
				fmtOk = bitCnt == `SFWP_BITS_ADDR;
			end
			`SFWP_OP_BE64:
			begin
				span = `SFWP_BLOCK64;
				dur = T_BERASE_CYC;
				fmtOk = bitCnt == `SFWP_BITS_ADDR;
			end
			`SFWP_OP_CE_A, `SFWP_OP_CE_B:
			begin
				span = `SFWP_ARRAY;
				dur = T_CHIP_CYC;
				fmtOk = bitCnt == `SFWP_BITS_OP;
			end
			`SFWP_OP_SREG_ERASE: dur = T_SERASE_CYC;
			default: dur = T_PROG_CYC;
		endcase
		if (srGo)
			dur = T_STATUS_CYC;
		tLo = {1'b0, addr & ~(span[20:0] - 21'h00_0001)};
		tHi = tLo + span;
	end

	assign hit = prot_hit(protectLevel, topBottomSelect, granularitySelect,
		invertProtection, tLo, tHi);
	assign lockHit = (addr[13:12] == 2'h0) || securityLock[addr[13:12] - 2'h1];
	// guard pin, only with quad lanes off
	assign guardBlock = statusWriteGuard && !quadIoEnable && !wpSync;
	assign freeOk = supplyOk && !pwrDown && (act != SFWP_RUN);
	assign wrenGo = csRise && freeOk && puDone && bitCnt == `SFWP_BITS_OP
		&& opcode == `SFWP_OP_WREN;
	assign wrdiGo = csRise && freeOk && bitCnt == `SFWP_BITS_OP
		&& opcode == `SFWP_OP_WRDI;
	assign srGo = csRise && freeOk && act == SFWP_IDLE && puDone && writeLatch
		&& !statusLockDown && !guardBlock && opcode == `SFWP_OP_WRSR
		&& (bitCnt == `SFWP_BITS_SR1 || bitCnt == `SFWP_BITS_SR2);
	assign arrGo = csRise && freeOk && act == SFWP_IDLE && puDone && writeLatch
		&& fmtOk && !hit;
	assign secGo = csRise && freeOk && act == SFWP_IDLE && puDone && writeLatch
		&& !lockHit && ((opcode == `SFWP_OP_SREG_ERASE
		&& bitCnt == `SFWP_BITS_ADDR) || (opcode == `SFWP_OP_SREG_PROG
		&& bitCnt >= `SFWP_BITS_DATA));
	assign startOp = srGo || arrGo || secGo;
	assign suspendGo = csRise && supplyOk && !pwrDown && act == SFWP_RUN
		&& !runIsStatus && bitCnt == `SFWP_BITS_OP
		&& op_is(opcode, `SFWP_OP_PAUSE_A, `SFWP_OP_PAUSE_B);
	assign resumeGo = csRise && supplyOk && !pwrDown && act == SFWP_PAUSED
		&& bitCnt == `SFWP_BITS_OP
		&& op_is(opcode, `SFWP_OP_RES_A, `SFWP_OP_RES_B);
	assign pdGo = csRise && freeOk && bitCnt == `SFWP_BITS_OP
		&& opcode == `SFWP_OP_PD;
	assign rpdGo = csRise && supplyOk && pwrDown && bitCnt == `SFWP_BITS_OP
		&& opcode == `SFWP_OP_RPD;
	assign endRun = act == SFWP_RUN && timer == 32'h0000_0001;
	assign newWord = (bitCnt == `SFWP_BITS_SR2)
		? {shiftSr[7:0], shiftSr[15:8]} : {statusWord[15:8], shiftSr[7:0]};

	// Serial side: bit shifting, opcode capture, status read-out
	always_comb
	begin
		next_bitCnt = bitCnt;
		next_shiftSr = shiftSr;
		next_opcode = opcode;
		next_addr = addr;
		next_reading = reading;
		next_readHigh = readHigh;
		next_outIdx = outIdx;
		next_miso = miso;
		next_misoOe = misoOe;
		if (!csActive)
		begin
			next_bitCnt = 6'h00;
			next_reading = 1'b0;
			next_misoOe = 1'b0;
		end
		else
		begin
			if (sclkRise)
			begin
				next_shiftSr = {shiftSr[30:0], mosiBit};
				if (bitCnt != `SFWP_BITS_MAX)
					next_bitCnt = bitCnt + 6'h01;
				if (bitCnt == `SFWP_BITS_OP - 6'h01)
				begin
					next_opcode = {shiftSr[6:0], mosiBit};
					// status read allowed even while busy
					next_reading = supplyOk && !pwrDown && op_is(next_opcode,
						`SFWP_OP_RDSR_LO, `SFWP_OP_RDSR_HI);
					next_readHigh = next_opcode == `SFWP_OP_RDSR_HI;
					next_outIdx = 3'h0;
				end
				if (bitCnt == `SFWP_BITS_ADDR - 6'h01)
					next_addr = {shiftSr[19:0], mosiBit};
			end
			if (sclkFall && reading)
			begin
				next_miso = statusWord[{readHigh, ~outIdx}];
				next_misoOe = 1'b1;
				next_outIdx = outIdx + 3'h1;
			end
		end
	end

	// Serial side registers
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			bitCnt <= 6'h00;
			shiftSr <= 32'h0000_0000;
			opcode <= 8'h00;
			addr <= 21'h00_0000;
			reading <= 1'b0;
			readHigh <= 1'b0;
			outIdx <= 3'h0;
			miso <= 1'b0;
			misoOe <= 1'b0;
		end
		else
		begin
			bitCnt <= next_bitCnt;
			shiftSr <= next_shiftSr;
			opcode <= next_opcode;
			addr <= next_addr;
			reading <= next_reading;
			readHigh <= next_readHigh;
			outIdx <= next_outIdx;
			miso <= next_miso;
			misoOe <= next_misoOe;
		end
	end

	// Control side: latch, busy timer, power states, status fields
	always_comb
	begin
		next_act = act;
		next_busy = busy;
		next_writeLatch = writeLatch;
		next_pausedOpFlag = pausedOpFlag;
		next_statusLockDown = statusLockDown;
		next_pwrDown = pwrDown;
		next_puDone = puDone;
		next_puCnt = puCnt;
		next_timer = timer;
		next_runIsStatus = runIsStatus;
		next_protectLevel = protectLevel;
		next_securityLock = securityLock;
		next_topBottomSelect = topBottomSelect;
		next_granularitySelect = granularitySelect;
		next_statusWriteGuard = statusWriteGuard;
		next_invertProtection = invertProtection;
		next_quadIoEnable = quadIoEnable;
		if (!puDone)
		begin
			next_puCnt = puCnt + 32'h0000_0001;
			next_puDone = puCnt >= T_PUW_CYC - 32'h0000_0001;
		end
		if (act == SFWP_RUN)
		begin
			next_timer = timer - 32'h0000_0001;
			if (endRun)
			begin
				next_act = SFWP_IDLE;
				next_busy = 1'b0;
			end
		end
		if (wrenGo)
			next_writeLatch = 1'b1;
		if (wrdiGo)
			next_writeLatch = 1'b0;
		if (startOp)
		begin
			next_act = SFWP_RUN;
			next_busy = 1'b1;
			next_writeLatch = 1'b0;
			next_timer = (dur == 32'h0000_0000) ? 32'h0000_0001 : dur;
			next_runIsStatus = srGo;
		end
		if (srGo)
		begin
			next_protectLevel = newWord[`SFWP_S_BP_HI:`SFWP_S_BP_LO];
			next_topBottomSelect = newWord[`SFWP_S_TOPBOT];
			next_granularitySelect = newWord[`SFWP_S_GRAN];
			next_statusWriteGuard = newWord[`SFWP_S_GUARD];
			next_invertProtection = newWord[`SFWP_S_INV];
			next_quadIoEnable = newWord[`SFWP_S_QUAD];
			next_securityLock = securityLock
				| newWord[`SFWP_S_SLOCK_HI:`SFWP_S_SLOCK_LO];
			next_statusLockDown = statusLockDown | newWord[`SFWP_S_LOCKDN];
		end
		if (suspendGo)
		begin
			next_act = SFWP_PAUSED;
			next_busy = 1'b0;
			next_pausedOpFlag = 1'b1;
		end
		if (resumeGo)
		begin
			next_act = SFWP_RUN;
			next_busy = 1'b1;
			next_pausedOpFlag = 1'b0;
		end
		if (pdGo)
			next_pwrDown = 1'b1;
		if (rpdGo)
			next_pwrDown = 1'b0;
		if (!supplyOk)
		begin
			next_act = SFWP_IDLE;
			next_busy = 1'b0;
			next_writeLatch = 1'b0;
			next_pausedOpFlag = 1'b0;
			next_statusLockDown = 1'b0;
			next_pwrDown = 1'b0;
			next_puDone = 1'b0;
			next_puCnt = 32'h0000_0000;
			next_timer = 32'h0000_0000;
		end
	end

	// Control registers; nonvolatile fields clear only on rstn
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			act <= SFWP_IDLE;
			busy <= 1'b0;
			writeLatch <= 1'b0;
			pausedOpFlag <= 1'b0;
			statusLockDown <= 1'b0;
			pwrDown <= 1'b0;
			puDone <= 1'b0;
			puCnt <= 32'h0000_0000;
			timer <= 32'h0000_0000;
			runIsStatus <= 1'b0;
			protectLevel <= `SFWP_BP_RST;
			securityLock <= `SFWP_SLOCK_RST;
			topBottomSelect <= 1'b0;
			granularitySelect <= 1'b0;
			statusWriteGuard <= 1'b0;
			invertProtection <= 1'b0;
			quadIoEnable <= 1'b0;
		end
		else
		begin
			act <= next_act;
			busy <= next_busy;
			writeLatch <= next_writeLatch;
			pausedOpFlag <= next_pausedOpFlag;
			statusLockDown <= next_statusLockDown;
			pwrDown <= next_pwrDown;
			puDone <= next_puDone;
			puCnt <= next_puCnt;
			timer <= next_timer;
			runIsStatus <= next_runIsStatus;
			protectLevel <= next_protectLevel;
			securityLock <= next_securityLock;
			topBottomSelect <= next_topBottomSelect;
			granularitySelect <= next_granularitySelect;
			statusWriteGuard <= next_statusWriteGuard;
			invertProtection <= next_invertProtection;
			quadIoEnable <= next_quadIoEnable;
		end
	end

	// Checks on the control side
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	sequence s_wren;
		wrenGo ##1 writeLatch;
	endsequence
	sequence s_start;
		startOp ##1 (busy && !writeLatch);
	endsequence
	sequence s_pause;
		pausedOpFlag && !busy ##1 pausedOpFlag;
	endsequence

	a_supply_reset: assert property (!supplyOk |=> !writeLatch && !busy)
		else $error("state not reset while supply low");
	a_powerup_hold: assert property (!puDone |-> !wrenGo && !startOp)
		else $error("write taken before power-up delay");
	a_start_latch: assert property (startOp |-> writeLatch)
		else $error("write started without latch");
	a_wren_sets: assert property (wrenGo && !startOp |-> s_wren)
		else $error("write enable did not set latch");
	a_start_busy: assert property (startOp |-> s_start)
		else $error("start did not raise busy and clear latch");
	a_busy_filter: assert property (
		act == SFWP_RUN |-> !startOp && !wrenGo)
		else $error("instruction taken while busy");
	a_pd_filter: assert property (pwrDown |-> !startOp && !wrenGo && !pdGo)
		else $error("instruction taken in power-down");
	a_guard_pin: assert property (srGo |-> !guardBlock && !statusLockDown)
		else $error("status write taken while guarded");
	a_lock_sticky: assert property (1'b1 |=>
		(securityLock & $past(securityLock)) == $past(securityLock))
		else $error("security lock bit cleared");
	a_suspend: assert property (suspendGo |=> s_pause)
		else $error("suspend flag not set");
	a_prot_hit: assert property (arrGo |-> !hit)
		else $error("protected region written");
endmodule : sfwp_protect

// File: verif/sfwp_spi_host.sv
// Behavioural SPI host model driving the flash bus in mode 0
`timescale 1ns/1ps
module sfwp_spi_host
(
	input wire logic mclk,
	input wire logic miso,
	output logic sclk,
	output logic csN,
	output logic mosi
);
	// Idle bus: clock parked low, chip deselected
	initial
	begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end
	// quad opcodes sent only as bits
	// One frame: n bits of d MSB first, miso caught at each clock rise
	task automatic frame(input logic [39:0] d, input int n,
		output logic [7:0] q);
		int i;
		q = 8'h00;
		@(negedge mclk);
		csN = 1'b0;
		for (i = n - 1; i >= 0; i--)
		begin
			mosi = d[i];
			repeat (4) @(negedge mclk);
			sclk = 1'b1;
			q = {q[6:0], miso};
			repeat (4) @(negedge mclk);
			sclk = 1'b0;
		end
		repeat (2) @(negedge mclk);
		csN = 1'b1;
		// Released data line shows the inverse of its last bit
		mosi = ~mosi;
		repeat (6) @(negedge mclk);
	endtask : frame
endmodule : sfwp_spi_host

// File: verif/sfwp_protect_test.sv
// Self-checking bench of the flash write-protection block
`timescale 1ns/1ps
`include "sfwp_regs.svh"
module sfwp_protect_test;
	import sfwp_pkg::*;
	logic mclk = 1'b0;
	logic rstn, wpNPin, supplyPin, sclk, csN, mosi;
	logic miso, misoOe, busy, writeLatch, quadIoEnable;
	logic [7:0] q;
	int nErrors = 0;
	int nCompared = 0;
	int cycles = 0;
	int oeCycles = 0;
	// 50 MHz system clock
	always #10 mclk = ~mclk;
	sfwp_protect #(.T_STATUS_CYC(300), .T_PROG_CYC(400),
		.T_SERASE_CYC(400), .T_BERASE_CYC(400),
		.T_PUW_CYC(200)) u_sfwp_protect (.mclk(mclk), .rstn(rstn),
		.sclkPin(sclk), .csNPin(csN), .mosiPin(mosi), .wpNPin(wpNPin),
		.supplyPin(supplyPin), .miso(miso), .misoOe(misoOe),
		.busy(busy), .writeLatch(writeLatch),
		.quadIoEnable(quadIoEnable));
	sfwp_spi_host u_sfwp_spi_host (.mclk(mclk), .miso(miso),
		.sclk(sclk), .csN(csN), .mosi(mosi));
	task automatic final_report;
		$display("compared %0d mismatches %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// Hang guard
	always @(posedge mclk)
	begin
		cycles++;
		// Cycles in which the data output is driven
		if (misoOe === 1'b1)
			oeCycles++;
		if (cycles == 30000)
		begin
			nErrors++;
			final_report;
		end
	end
	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		nCompared++;
		if (got !== exp)
		begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cmd(input logic [39:0] d, input int n);
		u_sfwp_spi_host.frame(d, n, q);
	endtask : cmd
	task automatic op(input logic [7:0] o);
		cmd({32'h0000_0000, o}, 8);
	endtask : op
	task automatic rdsr(input logic [7:0] o, output logic [7:0] s);
		u_sfwp_spi_host.frame({24'h00_0000, o, 8'h00}, 16, s);
	endtask : rdsr
	task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
		op(`SFWP_OP_WREN);
		cmd({16'h0000, `SFWP_OP_WRSR, lo, hi}, 24);
	endtask : wrsr
	task automatic erase(input logic [23:0] a, input logic [7:0] exp);
		op(`SFWP_OP_WREN);
		cmd({8'h00, `SFWP_OP_SE, a}, 32);
		chk("erase busy", exp, {7'h00, busy});
	endtask : erase
	task automatic wr32(input logic [7:0] o, input logic [23:0] a,
		input logic [7:0] exp);
		op(`SFWP_OP_WREN);
		cmd({8'h00, o, a}, 32);
		chk("op busy", exp, {7'h00, busy});
	endtask : wr32
	task automatic wait_idle;
		int k;
		for (k = 0; k < 1000 && busy !== 1'b0; k++)
			@(negedge mclk);
		chk("busy done", 8'h00, {7'h00, busy});
	endtask : wait_idle
	task automatic t_power;
		logic [7:0] s;
		int k;
		op(`SFWP_OP_WREN);
		chk("latch early", 8'h00, {7'h00, writeLatch});
		k = oeCycles;
		rdsr(`SFWP_OP_RDSR_LO, s);
		chk("status low", 8'h00, s);
		chk("oe seen", 8'h01, {7'h00, oeCycles > k});
		chk("oe off", 8'h00, {7'h00, misoOe});
		rdsr(`SFWP_OP_RDSR_HI, s);
		chk("status high", 8'h00, s);
		repeat (200) @(negedge mclk);
		op(`SFWP_OP_WREN);
		rdsr(`SFWP_OP_RDSR_LO, s);
		chk("latch set", 8'h02, s);
		op(`SFWP_OP_WRDI);
		chk("latch off", 8'h00, {7'h00, writeLatch});
		$display("test power done");
	endtask : t_power
	task automatic t_prog;
		logic [7:0] s;
		cmd({`SFWP_OP_PP, 24'h00_0000, 8'hA5}, 40);
		chk("pp no latch", 8'h00, {7'h00, busy});
		op(`SFWP_OP_WREN);
		cmd({`SFWP_OP_PP, 24'h00_0000, 8'hA5}, 40);
		chk("pp busy", 8'h01, {7'h00, busy});
		chk("pp latch", 8'h00, {7'h00, writeLatch});
		op(`SFWP_OP_WREN);
		chk("busy wren", 8'h00, {7'h00, writeLatch});
		rdsr(`SFWP_OP_RDSR_LO, s);
		chk("busy read", 8'h01, s);
		wait_idle;
		$display("test prog done");
	endtask : t_prog
	task automatic t_guard;
		logic [7:0] s;
		wpNPin = 1'b0;
		wrsr(8'h80, 8'h00);
		chk("guard off", 8'h01, {7'h00, busy});
		wait_idle;
		wrsr(8'h00, 8'h00);
		chk("guard pin low", 8'h00, {7'h00, busy});
		wpNPin = 1'b1;
		// Guard pin is driven, never tied, so quad lanes may be enabled
		wrsr(8'h84, 8'h02);
		chk("guard pin high", 8'h01, {7'h00, busy});
		wait_idle;
		chk("quad on", 8'h01, {7'h00, quadIoEnable});
		wpNPin = 1'b0;
		wrsr(8'h04, 8'h02);
		wait_idle;
		rdsr(`SFWP_OP_RDSR_LO, s);
		chk("quad pin ignored", 8'h04, s);
		wpNPin = 1'b1;
		$display("test guard done");
	endtask : t_guard
	task automatic t_protect;
		erase(24'h1F_0000, 8'h00);
		erase(24'h1E_F000, 8'h01);
		wait_idle;
		wrsr(8'h44, 8'h02);
		wait_idle;
		erase(24'h1F_E000, 8'h01);
		wait_idle;
		wrsr(8'h24, 8'h02);
		wait_idle;
		erase(24'h00_0000, 8'h00);
		erase(24'h1F_0000, 8'h01);
		wait_idle;
		wrsr(8'h24, 8'h42);
		wait_idle;
		erase(24'h1F_0000, 8'h00);
		erase(24'h00_0000, 8'h01);
		wait_idle;
		wrsr(8'h00, 8'h02);
		wait_idle;
		$display("test protect done");
	endtask : t_protect
	task automatic t_suspend;
		logic [7:0] s;
		int i;
		for (i = 0; i < 2; i++)
		begin
			erase(24'h00_0000, 8'h01);
			op(i == 0 ? `SFWP_OP_PAUSE_A : `SFWP_OP_PAUSE_B);
			rdsr(`SFWP_OP_RDSR_HI, s);
			chk("paused set", 8'h82, s);
			op(i == 0 ? `SFWP_OP_RES_A : `SFWP_OP_RES_B);
			rdsr(`SFWP_OP_RDSR_HI, s);
			chk("paused clear", 8'h02, s);
			chk("resumed busy", 8'h01, {7'h00, busy});
			wait_idle;
		end
		$display("test suspend done");
	endtask : t_suspend
	task automatic t_sleep;
		op(`SFWP_OP_PD);
		op(`SFWP_OP_WREN);
		chk("sleep wren", 8'h00, {7'h00, writeLatch});
		op(`SFWP_OP_RPD);
		op(`SFWP_OP_WREN);
		chk("wake wren", 8'h01, {7'h00, writeLatch});
		supplyPin = 1'b0;
		repeat (10) @(negedge mclk);
		supplyPin = 1'b1;
		repeat (5) @(negedge mclk);
		chk("supply drop", 8'h00, {7'h00, writeLatch});
		chk("quad kept", 8'h01, {7'h00, quadIoEnable});
		op(`SFWP_OP_WREN);
		chk("repower wren", 8'h00, {7'h00, writeLatch});
		$display("test sleep done");
	endtask : t_sleep
	task automatic t_lock;
		logic [7:0] s;
		repeat (210) @(negedge mclk);
		wr32(`SFWP_OP_SREG_ERASE, 24'h00_1000, 8'h01);
		wait_idle;
		wr32(`SFWP_OP_SREG_ERASE, 24'h00_0000, 8'h00);
		wrsr(8'h00, 8'h09);
		wait_idle;
		wr32(`SFWP_OP_SREG_ERASE, 24'h00_1000, 8'h00);
		wr32(`SFWP_OP_QPP, 24'h00_0000, 8'h00);
		wrsr(8'h00, 8'h02);
		chk("lock-down", 8'h00, {7'h00, busy});
		supplyPin = 1'b0;
		repeat (10) @(negedge mclk);
		supplyPin = 1'b1;
		repeat (210) @(negedge mclk);
		wrsr(8'h00, 8'h02);
		chk("lock released", 8'h01, {7'h00, busy});
		wait_idle;
		rdsr(`SFWP_OP_RDSR_HI, s);
		chk("lock kept", 8'h0A, s);
		wr32(`SFWP_OP_QPP, 24'h00_0000, 8'h01);
		wait_idle;
		$display("test lock done");
	endtask : t_lock
	// Main sequence
	initial
	begin
		rstn = 1'b0;
		wpNPin = 1'b1;
		supplyPin = 1'b1;
		repeat (4) @(negedge mclk);
		rstn = 1'b1;
		t_power;
		t_prog;
		t_guard;
		t_protect;
		t_suspend;
		t_sleep;
		t_lock;
		final_report;
	end
endmodule : sfwp_protect_test
